// file: hdl/rpps_map.vh
// register offsets, field positions and reset values for the rx port page select block
`ifndef RPPS_MAP_VH
`define RPPS_MAP_VH
`define RPPS_OFS_CAP 8'h4a
`define RPPS_OFS_EMB 8'h4b
`define RPPS_OFS_SEL 8'h4c
`define RPPS_PAGE_A_LO 8'h4d
`define RPPS_PAGE_A_HI 8'h7f
`define RPPS_PAGE_B_LO 8'hd0
`define RPPS_PAGE_B_HI 8'hdf
`define RPPS_CAP_CRC_BIT 4
`define RPPS_SEL_PHYS_BIT 6
`define RPPS_SEL_READ_BIT 4
`define RPPS_SEL_WR1_BIT 1
`define RPPS_SEL_WR0_BIT 0
`define RPPS_CAP_RESET 8'h10
`define RPPS_EMB_RESET 8'h12
`define RPPS_SEL_LOCAL_RESET 8'h00
`define RPPS_SEL_CC0_RESET 8'h01
`define RPPS_SEL_CC1_RESET 8'h12
`endif

// file: hdl/rpps_port_bank.v
// one receive port's paged register block with its embedded-type and crc-flag decisions
`timescale 1ns/1ps
`include "rpps_map.vh"
module rpps_port_bank
(
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // paged access
  input wire wr_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o,
  // data path hooks
  input wire csi_mode_i,
  input wire [1:0] long_pkt_index_i,
  input wire enc_crc_err_i,
  output reg embed_now_o,
  output reg [5:0] embed_type_o,
  output reg enc_crc_flag_o
);
  reg [7:0] cap;
  reg [7:0] emb;
  reg [7:0] page_a [0:50];
  reg [7:0] page_b [0:15];
  reg [7:0] rd;
  wire in_a;
  wire in_b;
  wire [7:0] idx_a;
  wire [7:0] idx_b;
  integer i;
  assign in_a = (addr_i >= `RPPS_PAGE_A_LO) && (addr_i <= `RPPS_PAGE_A_HI);
  assign in_b = (addr_i >= `RPPS_PAGE_B_LO) && (addr_i <= `RPPS_PAGE_B_HI);
  assign idx_a = addr_i - `RPPS_PAGE_A_LO;
  assign idx_b = addr_i - `RPPS_PAGE_B_LO;
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cap <= `RPPS_CAP_RESET;
      emb <= `RPPS_EMB_RESET;
      for (i = 0; i < 51; i = i + 1)
        page_a[i] <= 8'h00;
      for (i = 0; i < 16; i = i + 1)
        page_b[i] <= 8'h00;
    end
    else if (wr_en_i)
    begin
      if (addr_i == `RPPS_OFS_CAP)
        cap <= wdata_i;
      else if (addr_i == `RPPS_OFS_EMB)
        emb <= wdata_i;
      else if (in_a)
        page_a[idx_a[5:0]] <= wdata_i;
      else if (in_b)
        page_b[idx_b[3:0]] <= wdata_i;
    end
  end
  always @*
  begin
    rd = 8'h00;
    if (addr_i == `RPPS_OFS_CAP)
      rd = cap;
    else if (addr_i == `RPPS_OFS_EMB)
      rd = emb;
    else if (in_a)
      rd = page_a[idx_a[5:0]];
    else if (in_b)
      rd = page_b[idx_b[3:0]];
  end
  assign rdata_o = rd;
  // lines count 0 forwards all long packets as raw video
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      embed_now_o <= 1'b0;
      embed_type_o <= 6'h00;
      enc_crc_flag_o <= 1'b0;
    end
    else
    begin
      embed_now_o <= !csi_mode_i && (long_pkt_index_i < emb[7:6]);
      embed_type_o <= emb[5:0];
      enc_crc_flag_o <= enc_crc_err_i && cap[`RPPS_CAP_CRC_BIT];
    end
  end
endmodule // rpps_port_bank

// file: hdl/rpps_page_select.v
// paged register steering for two receive ports and three access sources
// How it works
// - paged accesses steered by port select register
// - read select bit picks one port block
// - read select defaults 0 locally, link port remotely
// - per-port write enables allow broadcast writes
// - write enables default off locally, own port remotely
// - bit 6 returns physical link number
// - each access source keeps its own page state
// - lines count picks embedded first long packets
// - embedded controls ignored in csi input mode
// - embedded type replaces raw type on first lines
// - encoder crc flag only when capability bit set
`timescale 1ns/1ps
`include "rpps_map.vh"
module rpps_page_select
(
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // register access: src 0 local i2c, 1 control channel port 0, 2 control channel port 1
  input wire [1:0] src_i,
  input wire wr_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o,
  // port 0 data path hooks
  input wire csi_mode0_i,
  input wire [1:0] long_pkt_index0_i,
  input wire enc_crc_err0_i,
  output wire embed_now0_o,
  output wire [5:0] embed_type0_o,
  output wire enc_crc_flag0_o,
  // port 1 data path hooks
  input wire csi_mode1_i,
  input wire [1:0] long_pkt_index1_i,
  input wire enc_crc_err1_i,
  output wire embed_now1_o,
  output wire [5:0] embed_type1_o,
  output wire enc_crc_flag1_o
);

  // page state per source: {read port, write enable 1, write enable 0}
  reg [2:0] page [0:2];
  reg [2:0] cur;
  reg [7:0] rd;

  // address decode results
  wire src_known;
  wire sel_hit;
  wire sel_wr;
  wire cap_hit;
  wire emb_hit;
  wire page_a_hit;
  wire page_b_hit;
  wire paged;

  // bank steering and readback
  wire wr_bank0;
  wire wr_bank1;
  wire phys;
  wire [7:0] sel_byte;
  wire [7:0] rd_bank;
  wire [7:0] rdata0;
  wire [7:0] rdata1;

  // inclusive address window test, shared by both high paged ranges
  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // select register byte to the three stored bits; read-only bits drop out
  function [2:0] pack_sel;
    input [7:0] v;
    begin
      pack_sel = {v[`RPPS_SEL_READ_BIT], v[`RPPS_SEL_WR1_BIT], v[`RPPS_SEL_WR0_BIT]};
    end
  endfunction

  // stored bits back to the register byte; reserved bits read as zero
  function [7:0] sel_readback;
    input [2:0] st;
    input ph;
    begin
      sel_readback = 8'h00;
      sel_readback[`RPPS_SEL_PHYS_BIT] = ph;
      sel_readback[`RPPS_SEL_READ_BIT] = st[2];
      sel_readback[`RPPS_SEL_WR1_BIT] = st[1];
      sel_readback[`RPPS_SEL_WR0_BIT] = st[0];
    end
  endfunction

  // write strobe of one bank: paged address and that bank's enable in the current page
  function bank_write;
    input wr;
    input pg;
    input en;
    begin
      bank_write = wr && pg && en;
    end
  endfunction

  // receive port carrying the source; local and unused sources report port 0
  function src_link;
    input [1:0] s;
    begin
      src_link = (s == 2'h2);
    end
  endfunction

  // reset page of each source: local reads port 0 with writes off,
  // a control channel reads and writes the port it arrived on
  localparam [2:0] SEL_LOCAL_DEF = pack_sel(`RPPS_SEL_LOCAL_RESET);
  localparam [2:0] SEL_CC0_DEF = pack_sel(`RPPS_SEL_CC0_RESET);
  localparam [2:0] SEL_CC1_DEF = pack_sel(`RPPS_SEL_CC1_RESET);

  assign sel_hit = (addr_i == `RPPS_OFS_SEL);
  assign cap_hit = (addr_i == `RPPS_OFS_CAP);
  assign emb_hit = (addr_i == `RPPS_OFS_EMB);
  assign page_a_hit = in_range(addr_i, `RPPS_PAGE_A_LO, `RPPS_PAGE_A_HI);
  assign page_b_hit = in_range(addr_i, `RPPS_PAGE_B_LO, `RPPS_PAGE_B_HI);
  assign paged = cap_hit || emb_hit || page_a_hit || page_b_hit;

  // source 3 has no page of its own; it uses the local reset page and cannot write the select register
  assign src_known = (src_i != 2'h3);
  assign sel_wr = wr_i && sel_hit && src_known;
  assign phys = src_link(src_i);

  // page of the source making this access
  always @*
  begin
    case (src_i)
      2'h0: cur = page[0];
      2'h1: cur = page[1];
      2'h2: cur = page[2];
      default: cur = SEL_LOCAL_DEF;
    endcase
  end

  // each source writes only its own page, so sources never disturb each other
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      page[0] <= SEL_LOCAL_DEF;
      page[1] <= SEL_CC0_DEF;
      page[2] <= SEL_CC1_DEF;
    end
    else if (sel_wr)
    begin
      case (src_i)
        2'h1: page[1] <= pack_sel(wdata_i);
        2'h2: page[2] <= pack_sel(wdata_i);
        default: page[0] <= pack_sel(wdata_i);
      endcase
    end
  end

  // a paged write lands in every enabled bank; with both enables clear nothing changes
  assign wr_bank0 = bank_write(wr_i, paged, cur[0]);
  assign wr_bank1 = bank_write(wr_i, paged, cur[1]);

  // port 0 register block
  rpps_port_bank u_bank0
  (
    // register side
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_bank0),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata0),
    // data path side
    .csi_mode_i(csi_mode0_i),
    .long_pkt_index_i(long_pkt_index0_i),
    .enc_crc_err_i(enc_crc_err0_i),
    .embed_now_o(embed_now0_o),
    .embed_type_o(embed_type0_o),
    .enc_crc_flag_o(enc_crc_flag0_o)
  );

  // port 1 register block
  rpps_port_bank u_bank1
  (
    // register side
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_bank1),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata1),
    // data path side
    .csi_mode_i(csi_mode1_i),
    .long_pkt_index_i(long_pkt_index1_i),
    .enc_crc_err_i(enc_crc_err1_i),
    .embed_now_o(embed_now1_o),
    .embed_type_o(embed_type1_o),
    .enc_crc_flag_o(enc_crc_flag1_o)
  );

  // select register readback carries the physical link number of the source
  assign sel_byte = sel_readback(cur, phys);
  // only one bank answers a read, even when writes go to both
  assign rd_bank = cur[2] ? rdata1 : rdata0;

  // read data is combinational so a read completes in the access cycle
  always @*
  begin
    rd = 8'h00;
    if (sel_hit)
      rd = sel_byte;
    else if (paged)
      rd = rd_bank;
  end
  assign rdata_o = rd;

  // software is expected to set capability bit 4 and clear the encoder crc disable
  // elsewhere; the reset value already enables the flag
endmodule // rpps_page_select

// file: sim/rpps_asserts.sv
// port-level checker for the rx port page select block
`timescale 1ns/1ps
module rpps_asserts
(
  // clock, reset and access
  input wire clock_i, rst_n_i, wr_i,
  input wire [1:0] src_i, long_pkt_index0_i, long_pkt_index1_i,
  input wire [7:0] addr_i, wdata_i, rdata_o,
  // data path hooks
  input wire csi_mode0_i, enc_crc_err0_i, embed_now0_o, enc_crc_flag0_o,
  input wire csi_mode1_i, enc_crc_err1_i, embed_now1_o, enc_crc_flag1_o,
  input wire [5:0] embed_type0_o, embed_type1_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire at_sel = addr_i == 8'h4c;
  a_crc_gate_p0: assert property (!enc_crc_err0_i |=> !enc_crc_flag0_o) else $error("flag0");
  a_crc_gate_p1: assert property (!enc_crc_err1_i |=> !enc_crc_flag1_o) else $error("flag1");
  a_csi_skip_p0: assert property (csi_mode0_i |=> !embed_now0_o) else $error("csi0");
  a_csi_skip_p1: assert property (csi_mode1_i |=> !embed_now1_o) else $error("csi1");
  a_idx_limit: assert property (long_pkt_index1_i == 2'h3 |=> !embed_now1_o) else $error("idx");
  a_phys_local: assert property (src_i == 2'h0 && at_sel |-> !rdata_o[6]) else $error("ph0");
  a_phys_remote: assert property (src_i == 2'h2 && at_sel |-> rdata_o[6]) else $error("ph1");
  a_sel_fixed: assert property (at_sel |-> (rdata_o & 8'hac) == 8'h00) else $error("rsv");
endmodule // rpps_asserts
bind rpps_page_select rpps_asserts u_chk (.*);

// file: sim/rpps_host.sv
// host model issuing register accesses
`timescale 1ns/1ps
module rpps_host
(
  input wire clock_i,
  output reg [1:0] src_o = 2'h0,
  output reg wr_o = 1'b0,
  output reg [7:0] addr_o = 8'h00,
  output reg [7:0] wdata_o = 8'h00
);
  // strobe held one edge only, so no write repeats
  task acc(input [1:0] s, input [7:0] a, input [7:0] d, input w);
    begin
      @(posedge clock_i);
      src_o <= s;
      addr_o <= a;
      wdata_o <= d;
      wr_o <= w;
      @(posedge clock_i);
      wr_o <= 1'b0;
      #1;
    end
  endtask
endmodule // rpps_host

// file: sim/tb.sv
// bench for the rx port page select block
`timescale 1ns/1ps
module tb;
  reg clock_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg csi_mode0_i = 1'b0, csi_mode1_i = 1'b0, enc_crc_err0_i = 1'b0, enc_crc_err1_i = 1'b0;
  reg [1:0] long_pkt_index0_i = 2'h0, long_pkt_index1_i = 2'h3;
  wire [1:0] src_i;
  wire wr_i, embed_now0_o, embed_now1_o, enc_crc_flag0_o, enc_crc_flag1_o;
  wire [7:0] addr_i, wdata_i, rdata_o;
  wire [5:0] embed_type0_o, embed_type1_o;
  integer error_cnt = 0, checks_done = 0, i;
  reg [17:0] rows [0:6];
  rpps_page_select u_dut (.*);
  rpps_host u_host (.clock_i, .src_o(src_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
  initial forever #2 clock_i = ~clock_i;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [1:0] s, input [7:0] a, input [7:0] exp);
    begin
      u_host.acc(s, a, 8'h00, 1'b0);
      chk(rdata_o, exp);
    end
  endtask
  // outputs are looked at one step after the edge, never at it
  task settle;
    begin
      repeat (2) @(posedge clock_i);
      #1;
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    rows[0] = {2'h0, 8'h4c, 8'h00};
    rows[1] = {2'h1, 8'h4c, 8'h01};
    rows[2] = {2'h2, 8'h4c, 8'h52};
    rows[3] = {2'h0, 8'h4a, 8'h10};
    rows[4] = {2'h0, 8'h4b, 8'h12};
    rows[5] = {2'h0, 8'h44, 8'h00};
    rows[6] = {2'h3, 8'h4c, 8'h00};
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
      rd(rows[i][17:16], rows[i][15:8], rows[i][7:0]);
    u_host.acc(2'h0, 8'h4b, 8'h41, 1'b1);
    rd(2'h0, 8'h4b, 8'h12);
    u_host.acc(2'h1, 8'h60, 8'h5a, 1'b1);
    rd(2'h2, 8'h60, 8'h00);
    rd(2'h1, 8'h60, 8'h5a);
    u_host.acc(2'h0, 8'h4c, 8'h03, 1'b1);
    u_host.acc(2'h0, 8'h4b, 8'h41, 1'b1);
    u_host.acc(2'h0, 8'hd5, 8'ha5, 1'b1);
    rd(2'h1, 8'h4c, 8'h01);
    rd(2'h2, 8'h4b, 8'h41);
    u_host.acc(2'h0, 8'h4c, 8'h01, 1'b1);
    u_host.acc(2'h0, 8'hd5, 8'h3c, 1'b1);
    rd(2'h0, 8'hd5, 8'h3c);
    rd(2'h2, 8'hd5, 8'ha5);
    chk({embed_now0_o, 1'b0, embed_type0_o}, 8'h81);
    long_pkt_index0_i <= 2'h1;
    long_pkt_index1_i <= 2'h0;
    enc_crc_err1_i <= 1'b1;
    settle;
    chk({7'h00, embed_now0_o}, 8'h00);
    chk({embed_now1_o, enc_crc_flag1_o, embed_type1_o}, 8'hc1);
    long_pkt_index0_i <= 2'h0;
    csi_mode0_i <= 1'b1;
    csi_mode1_i <= 1'b1;
    enc_crc_err0_i <= 1'b1;
    settle;
    chk({5'h00, embed_now1_o, embed_now0_o, enc_crc_flag0_o}, 8'h01);
    u_host.acc(2'h0, 8'h4a, 8'h00, 1'b1);
    settle;
    chk({6'h00, enc_crc_flag1_o, enc_crc_flag0_o}, 8'h02);
    u_host.acc(2'h0, 8'h4a, 8'h10, 1'b1);
    settle;
    chk({7'h00, enc_crc_flag0_o}, 8'h01);
    rst_n_i <= 1'b0;
    settle;
    rd(2'h1, 8'h60, 8'h00);
    rst_n_i <= 1'b1;
    rd(2'h0, 8'h4c, 8'h00);
    rd(2'h2, 8'h4b, 8'h12);
    results;
  end
endmodule // tb
